// file: core/cpmc_top.sv
// CPU power mode controller: idle and stop states behind an APB register
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module cpmc_top #(
	parameter int MCD_CYCLES = cpmc_pkg::MCD_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core handshake
	input wire logic instr_done,
	input wire logic irq_wake,
	input wire logic watchdog_expired,
	// Controls to the chip
	output cpmc_pkg::cpmc_ctl_type ctl,
	output logic wake_pulse,
	output logic reset_request,
	output logic restart_pulse,
	output logic [15:0] restart_addr
);
	cpmc_pkg::cpmc_mode_type mode_q, mode_d;
	logic pend_idle_q, pend_stop_q;
	logic [5:0] gpf_q;
	logic mcd_en_q, wdt_en_q, wdt_lock_q;
	logic [31:0] prdata_q, rdata_d;
	logic pready_q, pslverr_q;
	logic wake_q, rst_req_q, restart_q, booted_q;
	logic [15:0] restart_addr_q;
	logic [31:0] mcd_cnt_q;
	cpmc_pkg::cpmc_ctl_type ctl_q, ctl_d;

	wire setup = psel && !penable;
	wire access = psel && penable && pready_q;
	wire wr = access && pwrite;
	wire hit_pmc = paddr == cpmc_pkg::PMC_ADDR;
	wire hit_pmx = paddr == cpmc_pkg::PMX_ADDR;
	wire hit_pms = paddr == cpmc_pkg::PMS_ADDR;
	wire mapped = hit_pmc || hit_pmx || hit_pms;
	wire wr_pmc = wr && hit_pmc;
	wire wr_pmx = wr && hit_pmx;
	wire is_idle = mode_q == cpmc_pkg::CPMC_IDLE;
	wire is_stop = mode_q == cpmc_pkg::CPMC_STOP;
	wire enter_stop = pend_stop_q && instr_done;
	wire enter_idle = pend_idle_q && instr_done && !pend_stop_q;
	wire wdt_fire = wdt_en_q && watchdog_expired && !is_stop;
	wire mcd_fire = is_stop && mcd_en_q && mcd_cnt_q >= MCD_CYCLES - 1;
	// Disabling the watchdog is refused once the lock bit is set
	wire wdt_en_next = (pwdata[cpmc_pkg::WDT_EN_BIT] || wdt_lock_q);

	// Read data; select bits always read as 0
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_pmc) begin
			rdata_d[cpmc_pkg::GPF_MSB:cpmc_pkg::GPF_LSB] = gpf_q;
		end else if (hit_pmx) begin
			rdata_d[cpmc_pkg::MCD_EN_BIT] = mcd_en_q;
			rdata_d[cpmc_pkg::WDT_EN_BIT] = wdt_en_q;
			rdata_d[cpmc_pkg::WDT_LOCK_BIT] = wdt_lock_q;
		end else if (hit_pms) begin
			rdata_d[1:0] = mode_q;
		end
	end

	// Mode sequencing; an interrupt only matters in idle
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			cpmc_pkg::CPMC_RUN: begin
				if (enter_stop) begin
					mode_d = cpmc_pkg::CPMC_STOP;
				end else if (enter_idle) begin
					mode_d = cpmc_pkg::CPMC_IDLE;
				end
			end
			cpmc_pkg::CPMC_IDLE: begin
				if (irq_wake) begin
					mode_d = cpmc_pkg::CPMC_RUN;
				end
			end
			cpmc_pkg::CPMC_STOP: begin
				mode_d = cpmc_pkg::CPMC_STOP;
			end
			default: begin
				mode_d = cpmc_pkg::CPMC_RUN;
			end
		endcase
	end

	// Halted clocks in stop; idle only stops the CPU
	always_comb begin
		ctl_d.cpu_halt = mode_d != cpmc_pkg::CPMC_RUN;
		ctl_d.periph_clk_run = mode_d != cpmc_pkg::CPMC_STOP;
		ctl_d.osc_run = mode_d != cpmc_pkg::CPMC_STOP;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			prdata_q <= setup && !pwrite ? rdata_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gpf_q <= cpmc_pkg::GPF_RESET;
			mcd_en_q <= cpmc_pkg::MCD_EN_RESET;
			wdt_en_q <= cpmc_pkg::WDT_EN_RESET;
			wdt_lock_q <= 1'b0;
		end else begin
			if (wr_pmc) begin
				gpf_q <= pwdata[cpmc_pkg::GPF_MSB:cpmc_pkg::GPF_LSB];
			end
			if (wr_pmx) begin
				mcd_en_q <= pwdata[cpmc_pkg::MCD_EN_BIT];
				wdt_en_q <= wdt_en_next;
				wdt_lock_q <= wdt_lock_q || pwdata[cpmc_pkg::WDT_LOCK_BIT];
			end
		end
	end

	// Pending entry waits for the writing instruction to complete
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pend_idle_q <= 1'b0;
			pend_stop_q <= 1'b0;
		end else begin
			if (wr_pmc && pwdata[cpmc_pkg::IDLE_BIT]) begin
				pend_idle_q <= 1'b1;
			end else if (instr_done) begin
				pend_idle_q <= 1'b0;
			end
			if (wr_pmc && pwdata[cpmc_pkg::STOP_BIT]) begin
				pend_stop_q <= 1'b1;
			end else if (instr_done) begin
				pend_stop_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= cpmc_pkg::CPMC_RUN;
			ctl_q <= 3'b011;
			wake_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			ctl_q <= ctl_d;
			wake_q <= is_idle && irq_wake;
		end
	end

	// Clock detector count runs only in stop; the wide counter keeps
	// the default timeout reachable when the parameter is raised
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mcd_cnt_q <= 32'h0000_0000;
		end else if (is_stop && mcd_en_q && !mcd_fire) begin
			mcd_cnt_q <= mcd_cnt_q + 32'h0000_0001;
		end else if (!is_stop) begin
			mcd_cnt_q <= 32'h0000_0000;
		end
	end

	// The request holds until the system reset clears it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_req_q <= 1'b0;
			restart_q <= 1'b0;
			booted_q <= 1'b0;
			restart_addr_q <= cpmc_pkg::RESET_VECTOR;
		end else begin
			if (wdt_fire || mcd_fire) begin
				rst_req_q <= 1'b1;
			end
			booted_q <= 1'b1;
			restart_q <= !booted_q;
			restart_addr_q <= cpmc_pkg::RESET_VECTOR;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign ctl = ctl_q;
	assign wake_pulse = wake_q;
	assign reset_request = rst_req_q;
	assign restart_pulse = restart_q;
	assign restart_addr = restart_addr_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_idle_entry: assert property (mode_q == cpmc_pkg::CPMC_RUN && enter_idle
		|=> is_idle && ctl.cpu_halt && ctl.osc_run)
		else $error("idle not entered after instruction end");
	a_idle_hold: assert property (is_idle && !irq_wake
		|=> is_idle && ctl.periph_clk_run)
		else $error("idle left without wake");
	a_idle_wake: assert property (is_idle && irq_wake
		|=> !is_idle && wake_pulse ##1 !wake_pulse)
		else $error("interrupt wake from idle wrong");
	a_stop_entry: assert property (mode_q == cpmc_pkg::CPMC_RUN && enter_stop
		|=> is_stop && !ctl.osc_run && !ctl.periph_clk_run)
		else $error("stop not entered after instruction end");
	a_stop_sticky: assert property (is_stop |=> is_stop && !wake_pulse)
		else $error("stop left without reset");
	a_wdt_reset: assert property (is_idle && wdt_en_q && watchdog_expired
		|=> reset_request)
		else $error("watchdog did not request reset");
	a_mcd_reset: assert property (is_stop && mcd_en_q && !mcd_fire
		&& mcd_cnt_q == MCD_CYCLES - 2 |=> ##1 reset_request)
		else $error("clock detector timeout wrong");
	a_sel_read_zero: assert property (access && !pwrite && hit_pmc
		|-> prdata[1:0] == 2'b00)
		else $error("select bits read nonzero");
	a_gpf_write: assert property (wr_pmc
		|=> gpf_q == $past(pwdata[7:2]) && mode_q == $past(mode_d))
		else $error("flag write lost");
	a_boot_vector: assert property ($rose(booted_q)
		|-> restart_pulse && restart_addr == 16'h0000)
		else $error("restart not at address zero");

	// Clock controls must track the power state in every cycle
	a_run_clocks: assert property (mode_q == cpmc_pkg::CPMC_RUN
		|-> !ctl.cpu_halt && ctl.osc_run && ctl.periph_clk_run)
		else $error("run clocks wrong");
	a_idle_clocks: assert property (is_idle
		|-> ctl.cpu_halt && ctl.osc_run && ctl.periph_clk_run)
		else $error("idle clocks wrong");
	a_stop_clocks: assert property (is_stop
		|-> ctl.cpu_halt && !ctl.osc_run && !ctl.periph_clk_run)
		else $error("stop clocks wrong");
	a_stop_irq_ignored: assert property (is_stop && irq_wake
		|=> is_stop && !wake_pulse)
		else $error("interrupt woke stop");
	a_run_irq_ignored: assert property (mode_q == cpmc_pkg::CPMC_RUN
		&& !enter_idle && !enter_stop |=> mode_q == cpmc_pkg::CPMC_RUN)
		else $error("run left without entry");

	// Reset sources; a quiet source must never raise the request
	a_wdt_locked: assert property (wdt_lock_q && wdt_en_q
		|=> wdt_en_q)
		else $error("locked watchdog disabled");
	a_wdt_quiet: assert property (!wdt_en_q && !mcd_fire
		&& !reset_request |=> !reset_request)
		else $error("disabled watchdog reset");
	a_mcd_quiet: assert property (is_stop && !mcd_en_q
		&& !reset_request |=> !reset_request)
		else $error("disabled detector reset");
	a_mcd_early: assert property (is_stop && !reset_request
		&& mcd_cnt_q < MCD_CYCLES - 1 |=> !reset_request)
		else $error("detector reset too early");
	a_restart_once: assert property (booted_q && $past(booted_q)
		|-> !restart_pulse)
		else $error("restart pulse repeated");

	// Register side effects
	a_pend_clear: assert property (instr_done && !wr_pmc
		|=> !pend_idle_q && !pend_stop_q)
		else $error("pending entry not cleared");
	a_stop_priority: assert property (mode_q == cpmc_pkg::CPMC_RUN
		&& pend_stop_q && pend_idle_q && instr_done |=> is_stop)
		else $error("stop not preferred");
	a_gpf_hold: assert property (!wr_pmc |=> $stable(gpf_q))
		else $error("flags changed without write");
	a_wake_after_idle: assert property (wake_pulse
		|-> $past(is_idle) && !is_idle)
		else $error("wake pulse outside idle exit");
	a_pready_pulse: assert property (setup
		|=> pready ##1 !pready)
		else $error("ready not one cycle");
	a_flag_read: assert property (access && !pwrite && hit_pmc
		|-> prdata[7:2] == gpf_q)
		else $error("flag read wrong");
endmodule

// file: core/cpmc_pkg.sv
// Package for the CPU power mode controller: register map and constants
package cpmc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] PMC_INDEX = 12'h087;
	localparam logic [11:0] PMX_INDEX = 12'h088;
	localparam logic [11:0] PMS_INDEX = 12'h089;
	localparam logic [11:0] PMC_ADDR = 12'h21C;
	localparam logic [11:0] PMX_ADDR = 12'h220;
	localparam logic [11:0] PMS_ADDR = 12'h224;
	// Field positions in power_mode_control
	localparam int IDLE_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int GPF_LSB = 2;
	localparam int GPF_MSB = 7;
	// Field positions in the extension control register
	localparam int MCD_EN_BIT = 0;
	localparam int WDT_EN_BIT = 1;
	localparam int WDT_LOCK_BIT = 2;
	// Reset values
	localparam logic [5:0] GPF_RESET = 6'h00;
	localparam logic MCD_EN_RESET = 1'b0;
	localparam logic WDT_EN_RESET = 1'b1;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MCD_TIMEOUT_US = 100;
	localparam int MCD_CYCLES = (MCD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	// Power state of the core
	typedef enum logic [1:0] {
		CPMC_RUN = 2'b00,
		CPMC_IDLE = 2'b01,
		CPMC_STOP = 2'b10
	} cpmc_mode_type;
	// Clock and halt controls handed to the rest of the chip
	typedef struct packed {
		logic cpu_halt;
		logic periph_clk_run;
		logic osc_run;
	} cpmc_ctl_type;
endpackage

// file: sim/tb_top.sv
// Self-checking testbench for the CPU power mode controller
`timescale 1ns/1ps
module tb_top;
	localparam int MISSING_CLOCK_DETECTOR = 8;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, d;
	logic pready, pslverr, err, wake_pulse, reset_request, restart_pulse;
	logic instr_done = 1'b0, irq_wake = 1'b0, watchdog_expired = 1'b0;
	logic [15:0] restart_addr;
	cpmc_pkg::cpmc_ctl_type ctl;
	int n_mismatch = 0, samples_checked = 0, seed = 69448, mode_m = 0;
	logic [5:0] gpf_m = 6'h00;

	always #5 ref_clk = ~ref_clk;

	cpmc_top #(.MCD_CYCLES(MISSING_CLOCK_DETECTOR)) cpmc_top_i (.ref_clk(ref_clk),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_done(instr_done), .irq_wake(irq_wake),
		.watchdog_expired(watchdog_expired), .ctl(ctl),
		.wake_pulse(wake_pulse), .reset_request(reset_request),
		.restart_pulse(restart_pulse), .restart_addr(restart_addr));

	task wrap_up;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected {cpu_halt, periph_clk_run, osc_run} for run, idle, stop
	function automatic logic [31:0] ctl_exp(int m);
		return (m == 0) ? 32'h3 : (m == 1) ? 32'h7 : 32'h4;
	endfunction

	// Request holds until pready is seen at a rising edge; data taken there
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_mismatch++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task pulse_instr;
		@(posedge ref_clk);
		instr_done <= 1'b1;
		@(posedge ref_clk);
		instr_done <= 1'b0;
	endtask

	task pulse_irq;
		@(posedge ref_clk);
		irq_wake <= 1'b1;
		@(posedge ref_clk);
		irq_wake <= 1'b0;
	endtask

	task do_reset;
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		mode_m = 0;
		gpf_m = 6'h00;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk({31'h0, restart_pulse}, 32'h1);
		chk({16'h0, restart_addr}, 32'h0);
		chk({31'h0, reset_request}, 32'h0);
	endtask

	task chk_state;
		@(negedge ref_clk);
		chk({29'h0, ctl}, ctl_exp(mode_m));
		apb(1'b0, cpmc_pkg::PMS_ADDR, 32'h0);
		chk(rd & 32'h3, mode_m);
		apb(1'b0, cpmc_pkg::PMC_ADDR, 32'h0);
		chk(rd & 32'hFF, {24'h0, gpf_m, 2'b00});
	endtask

	initial begin
		#200000;
		n_mismatch++;
		wrap_up;
	end

	initial begin
		do_reset;
		chk_state;
		// Random flag patterns; select bits kept clear here
		repeat (4) begin
			d = $random(seed);
			d[1:0] = 2'b00;
			apb(1'b1, cpmc_pkg::PMC_ADDR, d);
			gpf_m = d[7:2];
			chk_state;
		end
		pulse_irq;
		@(negedge ref_clk);
		chk({31'h0, wake_pulse}, 32'h0);
		chk({29'h0, ctl}, ctl_exp(0));
		apb(1'b1, cpmc_pkg::PMC_ADDR, {24'h0, gpf_m, 2'b01});
		@(negedge ref_clk);
		chk({29'h0, ctl}, ctl_exp(0));
		pulse_instr;
		mode_m = 1;
		chk_state;
		pulse_irq;
		@(negedge ref_clk);
		chk({31'h0, wake_pulse}, 32'h1);
		mode_m = 0;
		chk({29'h0, ctl}, ctl_exp(0));
		@(negedge ref_clk);
		chk({31'h0, wake_pulse}, 32'h0);
		chk_state;
		// Watchdog is enabled out of reset and requests reset in idle
		apb(1'b1, cpmc_pkg::PMC_ADDR, 32'h1);
		pulse_instr;
		@(posedge ref_clk);
		watchdog_expired <= 1'b1;
		@(posedge ref_clk);
		watchdog_expired <= 1'b0;
		@(negedge ref_clk);
		chk({31'h0, reset_request}, 32'h1);
		do_reset;
		apb(1'b1, cpmc_pkg::PMX_ADDR, 32'h0);
		@(posedge ref_clk);
		watchdog_expired <= 1'b1;
		@(posedge ref_clk);
		watchdog_expired <= 1'b0;
		@(negedge ref_clk);
		chk({31'h0, reset_request}, 32'h0);
		// Both selects set: stop is taken, interrupts cannot wake it
		apb(1'b1, cpmc_pkg::PMX_ADDR, 32'h1);
		apb(1'b1, cpmc_pkg::PMC_ADDR, 32'h3);
		pulse_instr;
		mode_m = 2;
		irq_wake <= 1'b1;
		// Detector fires MISSING_CLOCK_DETECTOR edges after stop entry
		repeat (MISSING_CLOCK_DETECTOR - 1) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({31'h0, reset_request}, 32'h0);
		chk({29'h0, ctl}, ctl_exp(2));
		@(posedge ref_clk);
		irq_wake <= 1'b0;
		@(negedge ref_clk);
		chk({31'h0, reset_request}, 32'h1);
		do_reset;
		chk_state;
		apb(1'b0, 12'h300, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		wrap_up;
	end
endmodule
